//--- sci_status_flag_logic.sv
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
module sci_status_flag_logic
   import sci_status_pkg::*;
(
   input  wire logic       I_CLK_SYS,
   input  wire logic       I_RESETN,
   input  wire logic [7:0] I_ADDR,
   input  wire logic [7:0] I_WDATA,
   input  wire logic       I_WR,
   input  wire logic       I_RD,
   output logic      [7:0] O_RDATA,
   input  wire logic [7:0] I_RX_DATA,
   input  wire logic [7:0] I_CONTROL_THREE,
   input  wire logic       I_NINE_BIT_MODE,
   input  wire logic       I_IDLE_TYPE_SELECT,
   input  wire logic       I_PARITY_ENABLE,
   input  wire logic       I_TX_TRANSFER,
   input  wire logic       I_TX_ACTIVE,
   input  wire rx_event_t  I_RX_EVENT,
   input  wire logic       I_RX_START_DONE,
   input  wire logic       I_RX_STOP_DONE,
   input  wire logic       I_BIT_TICK,
   input  wire logic       I_RXD,
   output logic            O_RX_LOAD,
   output logic            O_TX_DATA_WRITE,
   output logic            O_TX_ENABLE_BIT,
   output logic            O_SEND_BREAK_BIT,
   output logic      [7:0] O_STATUS_ONE
);

   logic [7:0]  status;
   logic [7:0]  arm;
   logic [7:0]  set_v;
   logic [7:0]  clr_v;
   logic [7:0]  control_two;
   logic [7:0]  next_rdata;
   logic        status_rd;
   logic        data_rd;
   logic        data_wr;
   logic        ctrl3_rd;
   logic        ctrl2_wr;
   logic        te_rise;
   logic        sbk_one;
   logic        tx_kick;
   logic        next_tx_empty;
   logic        rx_clear;
   logic        data_seen;
   logic        ctrl3_seen;
   logic        rxd_s1;
   logic        rxd_s2;
   logic        rxd_s3;
   logic        rx_line;
   logic [3:0]  idle_cnt;
   logic [3:0]  idle_target;
   idle_phase_t idle_phase;
   logic        idle_detect;
   logic        idle_armed;
   logic        tx_buffer_empty_flag;
   logic        tx_complete_flag;
   logic        rx_buffer_full_flag;
   logic        noise_flag;
   logic        framing_error_flag;
   logic        parity_error_flag;

   assign tx_buffer_empty_flag = status[POS_TX_EMPTY];
   assign tx_complete_flag     = status[POS_TX_COMPLETE];
   assign rx_buffer_full_flag  = status[POS_RX_FULL];
   assign noise_flag           = status[POS_NOISE];
   assign framing_error_flag   = status[POS_FRAMING];
   assign parity_error_flag    = status[POS_PARITY];

   // status one never decoded for writes
   assign status_rd = I_RD && (I_ADDR == ADDR_STATUS_ONE);
   assign data_rd   = I_RD && (I_ADDR == ADDR_DATA_BUFFER);
   assign data_wr   = I_WR && (I_ADDR == ADDR_DATA_BUFFER);
   assign ctrl3_rd  = I_RD && (I_ADDR == ADDR_CONTROL_THREE);
   assign ctrl2_wr  = I_WR && (I_ADDR == ADDR_CONTROL_TWO);

   assign te_rise = ctrl2_wr && I_WDATA[POS_TX_ENABLE] && !control_two[POS_TX_ENABLE];
   assign sbk_one = ctrl2_wr && I_WDATA[POS_SEND_BREAK];
   assign tx_kick = data_wr || te_rise || sbk_one;

   assign O_TX_DATA_WRITE  = data_wr;
   assign O_TX_ENABLE_BIT  = control_two[POS_TX_ENABLE];
   assign O_SEND_BREAK_BIT = control_two[POS_SEND_BREAK];
   assign O_STATUS_ONE     = status;

   // a read that completes the clear in this cycle frees the buffer in time
   assign O_RX_LOAD = I_RX_EVENT.ready && (!rx_buffer_full_flag || rx_clear);

   // in nine-bit mode both reads needed, in either order
   always_comb begin
      if (I_NINE_BIT_MODE) begin
         rx_clear = arm[POS_RX_FULL] && (data_seen || data_rd) && (ctrl3_seen || ctrl3_rd);
      end else begin
         rx_clear = arm[POS_RX_FULL] && data_rd;
      end
   end

   always_comb begin
      clr_v = 8'h00;
      clr_v[POS_TX_EMPTY]    = arm[POS_TX_EMPTY] && data_wr;
      // read then any of three kicks
      clr_v[POS_TX_COMPLETE] = arm[POS_TX_COMPLETE] && tx_kick;
      clr_v[POS_RX_FULL]     = rx_clear;
      clr_v[POS_IDLE]        = arm[POS_IDLE] && data_rd;
      clr_v[POS_OVERRUN]     = arm[POS_OVERRUN] && data_rd;
      clr_v[POS_NOISE]       = arm[POS_NOISE] && data_rd;
      clr_v[POS_FRAMING]     = arm[POS_FRAMING] && data_rd;
      clr_v[POS_PARITY]      = arm[POS_PARITY] && data_rd;
   end

   // tx complete looks at the empty flag as it will be, so a kick cannot be undone
   assign next_tx_empty = I_TX_TRANSFER || (tx_buffer_empty_flag && !clr_v[POS_TX_EMPTY]);

   always_comb begin
      set_v = 8'h00;
      set_v[POS_TX_EMPTY]    = I_TX_TRANSFER;
      set_v[POS_TX_COMPLETE] = next_tx_empty && !I_TX_ACTIVE && !tx_kick;
      set_v[POS_RX_FULL]     = O_RX_LOAD;
      // only when armed by a character
      set_v[POS_IDLE]        = idle_detect && idle_armed;
      set_v[POS_OVERRUN]     = I_RX_EVENT.ready && !O_RX_LOAD;
      set_v[POS_NOISE]       = O_RX_LOAD && I_RX_EVENT.noise;
      set_v[POS_FRAMING]     = O_RX_LOAD && I_RX_EVENT.framing;
      set_v[POS_PARITY]      = O_RX_LOAD && I_RX_EVENT.parity_bad && I_PARITY_ENABLE;
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         status <= STATUS_ONE_RESET;
      end else begin
         status <= set_v | (status & ~clr_v);
      end
   end

   // remember a qualifying read, forget on new set
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         arm <= 8'h00;
      end else begin
         arm <= ~(set_v & ~status) & ~clr_v & (arm | ({8{status_rd}} & status));
      end
   end

   // track which half of the 9-bit read is done
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         data_seen  <= 1'b0;
         ctrl3_seen <= 1'b0;
      end else if (!arm[POS_RX_FULL] || rx_clear || set_v[POS_RX_FULL]) begin
         data_seen  <= 1'b0;
         ctrl3_seen <= 1'b0;
      end else begin
         data_seen  <= data_seen || data_rd;
         ctrl3_seen <= ctrl3_seen || ctrl3_rd;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         control_two <= CONTROL_TWO_RESET;
      end else if (ctrl2_wr) begin
         control_two <= I_WDATA;
      end
   end

   always_comb begin
      case (I_ADDR)
         ADDR_STATUS_ONE:    next_rdata = status;
         ADDR_DATA_BUFFER:   next_rdata = I_RX_DATA;
         ADDR_CONTROL_THREE: next_rdata = I_CONTROL_THREE;
         ADDR_CONTROL_TWO:   next_rdata = control_two;
         default:            next_rdata = READ_ZERO;
      endcase
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_RDATA <= READ_ZERO;
      end else if (I_RD) begin
         O_RDATA <= next_rdata;
      end else begin
         O_RDATA <= READ_ZERO;
      end
   end

   // receive pin: three stages, change accepted once the last two agree
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         rxd_s1  <= 1'b1;
         rxd_s2  <= 1'b1;
         rxd_s3  <= 1'b1;
         rx_line <= 1'b1;
      end else begin
         rxd_s1 <= I_RXD;
         rxd_s2 <= rxd_s1;
         rxd_s3 <= rxd_s2;
         if (rxd_s2 == rxd_s3) begin
            rx_line <= rxd_s3;
         end
      end
   end

   // character length picks the idle time
   assign idle_target = I_NINE_BIT_MODE ? IDLE_BITS_NINE : IDLE_BITS_EIGHT;
   assign idle_detect = (idle_phase == CNT_RUN) && I_BIT_TICK && rx_line
                        && ((idle_cnt + IDLE_CNT_ONE) == idle_target);

   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         idle_phase <= CNT_OFF;
         idle_cnt   <= IDLE_CNT_ZERO;
      end else if (I_RX_START_DONE) begin
         // start pulse lands while the line is still low, so it goes first
         idle_cnt <= IDLE_CNT_ZERO;
         // high data and stop bits count
         // held off until the stop bit
         idle_phase <= I_IDLE_TYPE_SELECT ? CNT_OFF : CNT_RUN;
      end else if (I_RX_STOP_DONE && I_IDLE_TYPE_SELECT) begin
         idle_cnt   <= IDLE_CNT_ZERO;
         idle_phase <= CNT_RUN;
      end else if (!rx_line) begin
         idle_cnt <= IDLE_CNT_ZERO;
         if (idle_phase == CNT_DONE) begin
            idle_phase <= CNT_OFF;
         end
      end else begin
         case (idle_phase)
            CNT_RUN: begin
               if (idle_detect) begin
                  idle_phase <= CNT_DONE;
               end else if (I_BIT_TICK) begin
                  idle_cnt <= idle_cnt + IDLE_CNT_ONE;
               end
            end
            CNT_OFF:  idle_cnt <= IDLE_CNT_ZERO;
            CNT_DONE: idle_cnt <= IDLE_CNT_ZERO;
            default:  idle_phase <= CNT_OFF;
         endcase
      end
   end

   // a long idle line sets the flag once only
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         idle_armed <= 1'b0;
      end else if (O_RX_LOAD) begin
         idle_armed <= 1'b1;
      end else if (set_v[POS_IDLE]) begin
         idle_armed <= 1'b0;
      end
   end

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESETN);

   sequence s_read_tx_empty;
      status_rd && tx_buffer_empty_flag && !I_TX_TRANSFER;
   endsequence

   sequence s_write_data;
      data_wr && !I_TX_TRANSFER;
   endsequence

   sequence s_read_rx_full;
      status_rd && rx_buffer_full_flag && !I_RX_EVENT.ready;
   endsequence

   sequence s_read_data_8;
      data_rd && !I_NINE_BIT_MODE && !I_RX_EVENT.ready;
   endsequence

   AST_TX_EMPTY_SET: assert property (I_TX_TRANSFER |=> tx_buffer_empty_flag)
      else $error("tx empty not set after transfer");

   AST_TX_EMPTY_CLR: assert property (s_read_tx_empty ##1 s_write_data |=> !tx_buffer_empty_flag)
      else $error("tx empty not cleared by read then write");

   AST_TX_COMPLETE_SET: assert property (
      (tx_buffer_empty_flag && !I_TX_ACTIVE && !tx_kick && !clr_v[POS_TX_EMPTY])
      |=> tx_complete_flag)
      else $error("tx complete not set while idle");

   AST_RX_FULL_SET: assert property (O_RX_LOAD |=> rx_buffer_full_flag)
      else $error("rx full not set on load");

   AST_RX_FULL_CLR8: assert property (s_read_rx_full ##1 s_read_data_8 |=> !rx_buffer_full_flag)
      else $error("rx full not cleared in 8-bit mode");

   AST_RX_FULL_HOLD9: assert property (
      (s_read_rx_full ##1 (data_rd && I_NINE_BIT_MODE && !ctrl3_seen))
      |=> rx_buffer_full_flag)
      else $error("rx full cleared by data read alone");

   AST_OVERRUN: assert property (
      (I_RX_EVENT.ready && rx_buffer_full_flag && !rx_clear)
      |-> !O_RX_LOAD ##1 status[POS_OVERRUN])
      else $error("overrun not flagged or character not dropped");

   AST_IDLE_ONCE: assert property ($rose(status[POS_IDLE]) |-> $past(idle_armed))
      else $error("idle set without new character");

   AST_FRAMING: assert property ((O_RX_LOAD && I_RX_EVENT.framing) |=> framing_error_flag)
      else $error("framing error not set");

   AST_PARITY_OFF: assert property (
      (O_RX_LOAD && !I_PARITY_ENABLE && !parity_error_flag) |=> !parity_error_flag)
      else $error("parity error set while disabled");

   AST_NOISE: assert property ((O_RX_LOAD && I_RX_EVENT.noise) |=> noise_flag)
      else $error("noise flag not set with load");

endmodule : sci_status_flag_logic

//--- sci_status_pkg.sv
package sci_status_pkg;

   // register offsets on the plain register port
   localparam logic [7:0] ADDR_CONTROL_TWO   = 8'h03;
   localparam logic [7:0] ADDR_STATUS_ONE    = 8'h04;
   localparam logic [7:0] ADDR_CONTROL_THREE = 8'h06;
   localparam logic [7:0] ADDR_DATA_BUFFER   = 8'h07;

   // status_one_reg field positions
   localparam int POS_TX_EMPTY    = 7;
   localparam int POS_TX_COMPLETE = 6;
   localparam int POS_RX_FULL     = 5;
   localparam int POS_IDLE        = 4;
   localparam int POS_OVERRUN     = 3;
   localparam int POS_NOISE       = 2;
   localparam int POS_FRAMING     = 1;
   localparam int POS_PARITY      = 0;

   // control_two_reg field positions
   localparam int POS_TX_ENABLE  = 3;
   localparam int POS_SEND_BREAK = 0;

   // reset values
   localparam logic [7:0] STATUS_ONE_RESET  = 8'hc0;
   localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO         = 8'h00;

   // idle character time in bit times
   localparam logic [3:0] IDLE_BITS_EIGHT = 4'ha;
   localparam logic [3:0] IDLE_BITS_NINE  = 4'hb;
   localparam logic [3:0] IDLE_CNT_ZERO   = 4'h0;
   localparam logic [3:0] IDLE_CNT_ONE    = 4'h1;

   // character handed over by the receive shifter
   typedef struct packed {
      logic ready;
      logic noise;
      logic framing;
      logic parity_bad;
   } rx_event_t;

   typedef enum logic [1:0] {
      CNT_OFF,
      CNT_RUN,
      CNT_DONE
   } idle_phase_t;

endpackage : sci_status_pkg

//--- serial_far_side.sv
`timescale 1ns/1ps
module serial_far_side
   import sci_status_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic       i_data_write,
   input  wire logic       i_te,
   input  wire logic       i_sbk,
   input  wire logic       i_send,
   input  wire logic       i_tail,
   input  wire logic [2:0] i_errs,
   output logic            o_tx_transfer,
   output logic            o_tx_active,
   output rx_event_t       o_rx_event,
   output logic            o_start_done,
   output logic            o_stop_done,
   output logic            o_bit_tick,
   output logic            o_rxd
);
   logic       te_q;
   logic [3:0] act_cnt;
   logic [3:0] rx_cnt;
   logic [1:0] div;

   // kicks must show activity in the very next cycle
   assign o_tx_active = (act_cnt != 4'h0) | (i_te & ~te_q) | i_sbk;
   assign o_bit_tick  = (div == 2'h3);
   // line low through start and data bits, pulled high otherwise
   // tail raises the last three data bits so idle counting can start early
   assign o_rxd       = (rx_cnt < 4'h2) || (i_tail && (rx_cnt < 4'h5));

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         te_q          <= 1'b0;
         act_cnt       <= 4'h0;
         o_tx_transfer <= 1'b0;
      end else begin
         te_q          <= i_te;
         o_tx_transfer <= i_data_write;
         if (i_data_write) begin
            act_cnt <= 4'h8;
         end else if (act_cnt != 4'h0) begin
            act_cnt <= act_cnt - 4'h1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         div          <= 2'h0;
         rx_cnt       <= 4'h0;
         o_start_done <= 1'b0;
         o_stop_done  <= 1'b0;
         o_rx_event   <= '0;
      end else begin
         div          <= div + 2'h1;
         o_start_done <= 1'b0;
         o_stop_done  <= 1'b0;
         o_rx_event   <= '0;
         if (i_send) begin
            rx_cnt <= 4'ha;
         end else if (o_bit_tick && rx_cnt != 4'h0) begin
            rx_cnt       <= rx_cnt - 4'h1;
            o_start_done <= (rx_cnt == 4'ha);
            if (rx_cnt == 4'h1) begin
               o_stop_done <= 1'b1;
               o_rx_event  <= rx_event_t'({1'b1, i_errs});
            end
         end
      end
   end
endmodule : serial_far_side

//--- tb.sv
`timescale 1ns/1ps
module tb;
   import sci_status_pkg::*;
   logic       clk, resetn, wr, rd, send, nine, idle_type_select, pe, rd_q, tail;
   logic       tx_transfer, tx_active, start_done, stop_done, bit_tick, rxd;
   logic       rx_load, data_write, te_bit, sbk_bit;
   logic [7:0] addr, wdata, rx_data, ctl3, rdata, status, e;
   logic [2:0] errs;
   rx_event_t  rx_event;
   logic [7:0] exp_q[$];
   int         err_count = 0;
   int         check_count = 0;
   int         n_load = 0;
   int         n_dw = 0;

   sci_status_flag_logic sci_status_flag_logic_inst (.I_CLK_SYS(clk), .I_RESETN(resetn),
      .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
      .I_RX_DATA(rx_data), .I_CONTROL_THREE(ctl3), .I_NINE_BIT_MODE(nine),
      .I_IDLE_TYPE_SELECT(idle_type_select), .I_PARITY_ENABLE(pe), .I_TX_TRANSFER(tx_transfer),
      .I_TX_ACTIVE(tx_active), .I_RX_EVENT(rx_event), .I_RX_START_DONE(start_done),
      .I_RX_STOP_DONE(stop_done), .I_BIT_TICK(bit_tick), .I_RXD(rxd), .O_RX_LOAD(rx_load),
      .O_TX_DATA_WRITE(data_write), .O_TX_ENABLE_BIT(te_bit), .O_SEND_BREAK_BIT(sbk_bit),
      .O_STATUS_ONE(status));

   serial_far_side serial_far_side_inst (.i_clk(clk), .i_resetn(resetn),
      .i_data_write(data_write), .i_te(te_bit), .i_sbk(sbk_bit), .i_send(send),
      .i_errs(errs), .i_tail(tail), .o_tx_transfer(tx_transfer), .o_tx_active(tx_active),
      .o_rx_event(rx_event), .o_start_done(start_done), .o_stop_done(stop_done),
      .o_bit_tick(bit_tick), .o_rxd(rxd));

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
      addr  <= a;
      wdata <= d;
      wr    <= w;
      rd    <= r;
      @(posedge clk);
   endtask : bus

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
      exp_q.push_back(x);
      bus(a, 8'h00, 1'b0, 1'b1);
   endtask : rd_chk

   task automatic st(input logic [7:0] mask, input logic [7:0] x);
      wr <= 1'b0;
      rd <= 1'b0;
      @(negedge clk);
      check("status", status & mask, x);
      @(posedge clk);
   endtask : st

   task automatic pause(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask : pause

   task automatic rx_frame();
      rx_data <= 8'($urandom);
      send    <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      for (int i = 0; i < 200 && rx_event.ready !== 1'b1; i++) @(posedge clk);
   endtask : rx_frame

   task automatic clear_rx(input logic [7:0] s);
      rd_chk(ADDR_STATUS_ONE, s);
      rd_chk(ADDR_DATA_BUFFER, rx_data);
   endtask : clear_rx

   // read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_q) begin
         check("rdata", rdata, exp_q.pop_front());
      end
      if (rx_load) begin
         n_load <= n_load + 1;
      end
      if (data_write) begin
         n_dw <= n_dw + 1;
      end
      rd_q <= rd;
   end

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      repeat (10000) @(posedge clk);
      err_count++;
      results();
   end

   initial begin
      {resetn, wr, rd, send, nine, idle_type_select, pe, tail, errs, addr, wdata} = '0;
      void'($urandom(32'h32bf88e5));
      rx_data = 8'($urandom);
      ctl3    = 8'($urandom);
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      st(8'hff, 8'hc0);
      rd_chk(ADDR_STATUS_ONE, 8'hc0);
      bus(ADDR_STATUS_ONE, 8'($urandom), 1'b1, 1'b0);
      st(8'hff, 8'hc0);
      rd_chk(8'hf0, READ_ZERO);
      $display("test registers done");
      rd_chk(ADDR_STATUS_ONE, 8'hc0);
      bus(ADDR_DATA_BUFFER, 8'($urandom), 1'b1, 1'b0);
      st(8'hff, 8'h00);
      pause(1);
      st(8'hff, 8'h80);
      pause(12);
      st(8'hff, 8'hc0);
      bus(ADDR_DATA_BUFFER, 8'($urandom), 1'b1, 1'b0);
      st(8'h80, 8'h80);
      pause(12);
      rd_chk(ADDR_STATUS_ONE, 8'hc0);
      bus(ADDR_CONTROL_TWO, 8'h08, 1'b1, 1'b0);
      st(8'hff, 8'h80);
      pause(3);
      st(8'hff, 8'hc0);
      rd_chk(ADDR_STATUS_ONE, 8'hc0);
      bus(ADDR_CONTROL_TWO, 8'h09, 1'b1, 1'b0);
      st(8'hff, 8'h80);
      check("te_sbk", {6'h00, te_bit, sbk_bit}, 8'h03);
      rd_chk(ADDR_CONTROL_TWO, 8'h09);
      bus(ADDR_CONTROL_TWO, 8'h08, 1'b1, 1'b0);
      pause(3);
      st(8'hff, 8'hc0);
      $display("test transmit done");
      for (int k = 0; k < 16; k++) begin
         pe   <= k[3];
         errs <= k[2:0];
         rx_frame();
         e = 8'he0 | {5'h0, errs[2:1], errs[0] & pe};
         st(8'hff, e);
         clear_rx(e);
         st(8'hff, 8'hc0);
      end
      errs <= 3'h0;
      rx_frame();
      errs <= 3'h7;
      rx_frame();
      st(8'hff, 8'he8);
      clear_rx(8'he8);
      st(8'hff, 8'hc0);
      $display("test receive done");
      nine <= 1'b1;
      errs <= 3'h0;
      rx_frame();
      clear_rx(8'he0);
      st(8'hff, 8'he0);
      rd_chk(ADDR_CONTROL_THREE, ctl3);
      st(8'hff, 8'hc0);
      tail <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         idle_type_select  <= k[0];
         nine <= k[0];
         rx_frame();
         clear_rx(8'he0);
         rd_chk(ADDR_CONTROL_THREE, ctl3);
         // high tail counts only with select 0, so idle comes earlier there
         pause(34);
         st(8'hff, k[0] ? 8'hc0 : 8'hd0);
         pause(30);
         st(8'hff, 8'hd0);
         clear_rx(8'hd0);
         st(8'hff, 8'hc0);
         pause(100);
         st(8'hff, 8'hc0);
      end
      $display("test idle done");
      pause(2);
      check("loads", 8'(n_load), 8'h14);
      check("data writes", 8'(n_dw), 8'h02);
      results();
   end
endmodule : tb
